// ==== hw/dqc_chain.sv ====
// How it works
// [RULE_01] two parallel one-biquad paths blended by the sensed level
// [RULE_02] sense biquad then alpha-filter energy sets the blend
// [RULE_03] offset, gain and alpha blend coefficients in 1.31
// [RULE_04] blend alpha at 0x44, gain at 0x48, offset at 0x4c
// [RULE_05] blend biquads use 1.31 coefficients with no gain scale
// [RULE_06] sense gain scales the sensed signal, moving the thresholds
// [RULE_07] compressors are feed-forward on an alpha-filter energy
// [RULE_08] seven transfer parameters: two thresholds, three slopes, offsets
// [RULE_09] offsets shift the curve from 1:1 at each threshold
// [RULE_10] two bands split by a crossover biquad, summed after
// [RULE_11] each band has its own energy, attack and decay constants
// [RULE_12] limiter measures energy at its own output versus threshold
// [RULE_13] limiter engages at attack rate, releases at release rate
// [RULE_14] host programs release longer than attack
// [RULE_15] fine volume after the limiter in 2.30
// [RULE_16] boost with volume clips at a programmable level
// [RULE_17] meter energy per channel readable as 1.31
// [RULE_18] bit at 0x70 picks meter input before or after processing
// [RULE_19] 32-bit samples and 32-bit two's complement coefficients
// [RULE_20] host saturates 1.31 gains below one
// [RULE_21] new coefficients take effect only when the swap flag is written
// [RULE_22] blend: low path below, high path above, linear between
`timescale 1ns/10ps
`default_nettype none
module dqc_fifo
   import dqc_pkg::*;
#(
   parameter int W = 33,
   parameter int DEPTH = 16
)
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic in_valid_in,
   input wire logic [W-1:0] in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output logic [W-1:0] out_data_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
   } dqc_fst_t;
   dqc_fst_t s_r, s_nxt;
   logic full;
   logic empty;

   assign empty = s_r.wp == s_r.rp;
   assign full = (s_r.wp[AW] != s_r.rp[AW]) &&
      (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]);
   assign in_ready_out = !full;
   assign out_valid_out = !empty;
   assign out_data_out = s_r.mem[s_r.rp[AW-1:0]];

   always_comb
   begin
      s_nxt = s_r;
      if (in_valid_in && !full)
      begin
         s_nxt.mem[s_r.wp[AW-1:0]] = in_data_in;
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (out_ready_in && !empty)
         s_nxt.rp = s_r.rp + 1'b1;
      if (sys_rst_in)
         s_nxt = '0;
   end

   always_ff @(posedge ref_clk_in)
      s_r <= s_nxt;
endmodule

module dqc_chain
   import dqc_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   output logic [31:0] reg_rdata_out,
   input wire logic in_valid_in,
   input wire dqc_smp_t in_data_in,
   output logic in_ready_out,
   output logic out_valid_out,
   output dqc_smp_t out_data_out,
   input wire logic out_ready_in
);
   typedef logic signed [31:0] s32_t;
   typedef logic signed [63:0] s64_t;

   dqc_st_t s_r, s_nxt;
   logic f_vld;
   dqc_smp_t f_dat;
   logic go;
   logic c;
   s32_t x, hp, lp, sn, de, rt, dq, range_compressor, ly, le, lg, vol, bst, cl, y, me;
   s32_t thr, lg0, att;
   s32_t bin [2];
   s32_t be [2];
   s32_t bg [2];
   s32_t bo [2];

   function automatic s32_t sat(input s64_t v);
      if (v > s64_t'(32'sh7fffffff))
         return 32'sh7fffffff;
      if (v < -s64_t'(32'sh7fffffff))
         return -32'sh7fffffff;
      return v[31:0];
   endfunction

   function automatic s32_t mul(input s64_t a, input s64_t b,
                                input int sh);
      logic signed [127:0] p;
      p = (128'(a) * 128'(b)) >>> sh;
      return sat(p[63:0]);
   endfunction

   // direct form 1, b1 and a1 stored halved
   function automatic s32_t bq(input logic [4:0][31:0] k,
                               input s32_t xi,
                               input logic [3:0][31:0] t);
      s64_t acc;
      acc = s64_t'(mul($signed(k[0]), xi, FR_Q31))
         + s64_t'(mul($signed(k[1]), $signed(t[0]), FR_Q30))
         + s64_t'(mul($signed(k[2]), $signed(t[1]), FR_Q31))
         + s64_t'(mul($signed(k[3]), $signed(t[2]), FR_Q30))
         + s64_t'(mul($signed(k[4]), $signed(t[3]), FR_Q31));
      return sat(acc);
   endfunction

   function automatic logic [3:0][31:0] tap(input logic [3:0][31:0] t,
                                            input s32_t xi,
                                            input s32_t yo);
      return {t[2], yo, t[0], xi};
   endfunction

   // alpha-filter energy on the magnitude
   function automatic s32_t ema(input logic [31:0] e, input s32_t v,
                                input logic [31:0] a);
      s64_t m;
      m = (v < 0) ? -s64_t'(v) : s64_t'(v);
      return sat(s64_t'($signed(e))
         + s64_t'(mul($signed(a), m - s64_t'($signed(e)), FR_Q31)));
   endfunction

   // 16 words of input buffering; the chain stalls when output is held
   dqc_fifo #(.W($bits(dqc_smp_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .in_valid_in(in_valid_in),
      .in_data_in(in_data_in),
      .in_ready_out(in_ready_out),
      .out_valid_out(f_vld),
      .out_data_out(f_dat),
      .out_ready_in(go)
   );

   assign go = f_vld && (!s_r.ov || out_ready_in);
   assign out_valid_out = s_r.ov;
   assign out_data_out = s_r.od;
   assign reg_rdata_out = s_r.rdata;

   always_comb
   begin
      s_nxt = s_r;
      c = f_dat.ch;
      x = $signed(f_dat.smp); // RULE_19
      // blend paths only read the active set
      hp = bq(s_r.act[I_HI_BQ +: 5], x, s_r.bq[0][c]); // RULE_01 RULE_05
      lp = bq(s_r.act[I_LO_BQ +: 5], x, s_r.bq[1][c]); // RULE_01 RULE_05
      sn = mul(bq(s_r.act[I_SN_BQ +: 5], x, s_r.bq[2][c]),
               $signed(s_r.act[I_SN_GAIN]), FR_Q30); // RULE_02 RULE_06
      de = ema(s_r.deq_e[c], sn, s_r.act[I_DEQ_ALPHA]); // RULE_02 RULE_03
      // ratio = 32 * gain * (energy + offset), clamped to [0,1)
      rt = mul(s64_t'(de) + s64_t'($signed(s_r.act[I_DEQ_OFFSET])),
               $signed(s_r.act[I_DEQ_GAIN]), FR_RATIO); // RULE_03
      if (rt < 0)
         rt = '0; // RULE_22
      dq = sat(s64_t'(lp) + s64_t'(mul(rt, s64_t'(hp) - s64_t'(lp),
               FR_Q31))); // RULE_22
      bin[0] = bq(s_r.act[I_XO_BQ +: 5], dq, s_r.bq[3][c]); // RULE_10
      // high band is the complement, so the bands sum back flat
      bin[1] = sat(s64_t'(dq) - s64_t'(bin[0])); // RULE_10
      for (int b = 0; b < 2; b++)
      begin
         s64_t t1, t2, tl;
         int i;
         i = I_DRC0 + b * DRC_N;
         t1 = $signed(s_r.act[i]);
         t2 = $signed(s_r.act[i + 1]);
         tl = '0;
         be[b] = ema(s_r.drc_e[b][c], bin[b], s_r.act[i + 7]); // RULE_07
         // target level per region, offset from 1:1 at each threshold
         if (be[b] < t1)
            tl = t1 + $signed(s_r.act[i + 5]) + mul($signed(s_r.act[i + 2]),
               be[b] - t1, FR_SLOPE); // RULE_08 RULE_09
         else if (be[b] < t2)
            tl = t1 + $signed(s_r.act[i + 5]) + mul($signed(s_r.act[i + 3]),
               be[b] - t1, FR_SLOPE); // RULE_08 RULE_09
         else
            tl = t2 + $signed(s_r.act[i + 6]) + mul($signed(s_r.act[i + 4]),
               be[b] - t2, FR_SLOPE); // RULE_08 RULE_09
         if (s64_t'(mul(be[b], $signed(s_r.drc_g[b][c]), FR_Q31)) > tl)
            bg[b] = sat(s64_t'($signed(s_r.drc_g[b][c]))
               - mul($signed(s_r.drc_g[b][c]), $signed(s_r.act[i + 8]),
               FR_Q31)); // RULE_11
         else
            bg[b] = sat(s64_t'($signed(s_r.drc_g[b][c]))
               + mul(s64_t'(ONE_Q31) - $signed(s_r.drc_g[b][c]),
               $signed(s_r.act[i + 9]), FR_Q31)); // RULE_11
         bo[b] = mul(bin[b], bg[b], FR_Q31); // RULE_07
      end
      range_compressor = sat(s64_t'(bo[0]) + s64_t'(bo[1])); // RULE_10
      // limiter decides on energy already measured at its output
      thr = $signed(s_r.act[I_LIM_THR]);
      ly = mul(range_compressor, $signed(s_r.lim_g[c]), FR_Q31);
      le = ema(s_r.lim_e[c], ly, s_r.act[I_LIM_ALPHA]); // RULE_12
      lg0 = $signed(s_r.lim_g[c]);
      att = $signed(s_r.act[I_LIM_ATT]);
      lg = lg0;
      if ($signed(s_r.lim_e[c]) > thr)
         lg = (lg0 > att) ? lg0 - att : '0; // RULE_13
      else if ($signed(s_r.lim_e[c]) < thr)
         lg = sat(s64_t'(lg) + $signed(s_r.act[I_LIM_REL])); // RULE_13
      vol = mul(ly, $signed(s_r.act[I_VOL]), FR_Q30); // RULE_15
      bst = mul(vol, $signed(s_r.act[I_BOOST]), FR_Q30); // RULE_16
      cl = $signed(s_r.act[I_CLIP]);
      if (bst > cl)
         y = cl; // RULE_16
      else if (bst < -cl)
         y = -cl; // RULE_16
      else
         y = bst;
      me = ema(s_r.met_e[c], s_r.act[I_METER_SEL][0] ? x : y,
               s_r.act[I_MET_ALPHA]); // RULE_17 RULE_18
      if (go)
      begin
         s_nxt.bq[0][c] = tap(s_r.bq[0][c], x, hp);
         s_nxt.bq[1][c] = tap(s_r.bq[1][c], x, lp);
         s_nxt.bq[2][c] = tap(s_r.bq[2][c], x,
            bq(s_r.act[I_SN_BQ +: 5], x, s_r.bq[2][c]));
         s_nxt.bq[3][c] = tap(s_r.bq[3][c], dq, bin[0]);
         s_nxt.deq_e[c] = de;
         for (int b = 0; b < 2; b++)
         begin
            s_nxt.drc_e[b][c] = be[b];
            s_nxt.drc_g[b][c] = bg[b];
         end
         s_nxt.lim_e[c] = le;
         s_nxt.lim_g[c] = lg;
         s_nxt.met_e[c] = me; // RULE_17
         s_nxt.ov = 1'b1;
         s_nxt.od = '{ch: c, smp: y};
      end
      else if (out_ready_in)
         s_nxt.ov = 1'b0;
      if (reg_wr_in)
      begin
         if (reg_addr_in == OFS_SWAP)
         begin
            if (reg_wdata_in[0])
               s_nxt.act = s_r.shd; // RULE_21
         end
         else if (reg_addr_in != OFS_METER_L && reg_addr_in != OFS_METER_R)
            s_nxt.shd[reg_addr_in[7:2]] = reg_wdata_in; // RULE_04
      end
      case (reg_addr_in)
         OFS_METER_L: s_nxt.rdata = s_r.met_e[0]; // RULE_17
         OFS_METER_R: s_nxt.rdata = s_r.met_e[1]; // RULE_17
         OFS_SWAP: s_nxt.rdata = '0;
         default: s_nxt.rdata = s_r.shd[reg_addr_in[7:2]];
      endcase
      if (sys_rst_in)
      begin
         s_nxt = '0;
         // unity volume, boost and full clip so the output stages pass audio after reset
         s_nxt.shd[I_VOL] = ONE_Q30;
         s_nxt.shd[I_BOOST] = ONE_Q30;
         s_nxt.shd[I_CLIP] = ONE_Q31;
         s_nxt.act[I_VOL] = ONE_Q30;
         s_nxt.act[I_BOOST] = ONE_Q30;
         s_nxt.act[I_CLIP] = ONE_Q31;
         s_nxt.lim_g = {ONE_Q31, ONE_Q31};
         s_nxt.drc_g = {ONE_Q31, ONE_Q31, ONE_Q31, ONE_Q31};
      end
   end

   always_ff @(posedge ref_clk_in)
      s_r <= s_nxt;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_gain_wr;
      reg_wr_in && reg_addr_in == OFS_DEQ_GAIN;
   endsequence
   sequence s_gain_rd;
      !reg_wr_in && reg_addr_in == OFS_DEQ_GAIN;
   endsequence

   AST_SWAP_LOAD: assert property ( // RULE_21
      reg_wr_in && reg_addr_in == OFS_SWAP && reg_wdata_in[0]
      |=> s_r.act == $past(s_r.shd))
      else $error("swap did not load the new set");
   AST_SWAP_HOLD: assert property ( // RULE_21
      !(reg_wr_in && reg_addr_in == OFS_SWAP) |=> $stable(s_r.act))
      else $error("active set changed without swap");
   AST_DEQ_RDBACK: assert property ( // RULE_04
      s_gain_wr ##1 s_gain_rd |=> reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("blend gain word readback wrong");
   AST_MIX_LOW: assert property ( // RULE_22
      go && rt == 0 |-> dq == lp)
      else $error("zero ratio did not pass low path");
   AST_LIM_ENG: assert property ( // RULE_13
      go && $signed(s_r.lim_e[c]) > thr && lg0 > att
      |=> $signed(s_r.lim_g[$past(c)]) == $past(lg0) - $past(att))
      else $error("limiter did not attack");
   AST_LIM_REL: assert property ( // RULE_13
      go && $signed(s_r.lim_e[c]) < thr
      |=> $signed(s_r.lim_g[$past(c)]) >= $past(lg0))
      else $error("limiter gain fell while releasing");
   AST_CLIP: assert property ( // RULE_16
      go |=> $signed(out_data_out.smp) <= $past(cl)
      && $signed(out_data_out.smp) >= -$past(cl))
      else $error("output beyond clip level");
   AST_OUT_HOLD: assert property ( // RULE_19
      out_valid_out && !out_ready_in |=> out_valid_out
      && $stable(out_data_out))
      else $error("held output changed");
endmodule
`default_nettype wire

// ==== hw/dqc_pkg.sv ====
package dqc_pkg;
   // register byte offsets on the coefficient port
   localparam logic [7:0] OFS_DEQ_ALPHA = 8'h44;
   localparam logic [7:0] OFS_DEQ_GAIN = 8'h48;
   localparam logic [7:0] OFS_DEQ_OFFSET = 8'h4c;
   localparam logic [7:0] OFS_METER_SEL = 8'h70;
   localparam logic [7:0] OFS_METER_L = 8'h74;
   localparam logic [7:0] OFS_METER_R = 8'h78;
   localparam logic [7:0] OFS_SWAP = 8'h7c;
   localparam int NWORDS = 64;
   // word indices (byte offset / 4)
   localparam int I_HI_BQ = 0;
   localparam int I_LO_BQ = 5;
   localparam int I_SN_BQ = 10;
   localparam int I_SN_GAIN = 15;
   localparam int I_VOL = 16;
   localparam int I_DEQ_ALPHA = 17;
   localparam int I_DEQ_GAIN = 18;
   localparam int I_DEQ_OFFSET = 19;
   localparam int I_BOOST = 20;
   localparam int I_CLIP = 21;
   localparam int I_MET_ALPHA = 22;
   localparam int I_METER_SEL = 28;
   localparam int I_XO_BQ = 32;
   localparam int I_DRC0 = 40;
   localparam int DRC_N = 10;
   localparam int I_LIM_THR = 60;
   localparam int I_LIM_ALPHA = 61;
   localparam int I_LIM_ATT = 62;
   localparam int I_LIM_REL = 63;
   // fixed point fraction widths
   localparam int FR_Q31 = 31;
   localparam int FR_Q30 = 30;
   localparam int FR_SLOPE = 28;
   localparam int FR_RATIO = 26;
   // values after reset and the input FIFO depth
   localparam logic [31:0] ONE_Q31 = 32'h7fffffff;
   localparam logic [31:0] ONE_Q30 = 32'h40000000;
   localparam logic [31:0] FIFO_DEPTH = 32'h00000010;

   typedef struct packed {
      logic ch;
      logic [31:0] smp;
   } dqc_smp_t;

   typedef struct packed {
      logic [NWORDS-1:0][31:0] shd;
      logic [NWORDS-1:0][31:0] act;
      logic [3:0][1:0][3:0][31:0] bq;
      logic [1:0][31:0] deq_e;
      logic [1:0][31:0] lim_e;
      logic [1:0][31:0] lim_g;
      logic [1:0][31:0] met_e;
      logic [1:0][1:0][31:0] drc_e;
      logic [1:0][1:0][31:0] drc_g;
      logic [31:0] rdata;
      logic ov;
      dqc_smp_t od;
   } dqc_st_t;
endpackage

// ==== sim/dqc_up_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module dqc_up_model
   import dqc_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic ready_in,
   output logic valid_out,
   output dqc_smp_t data_out
);
   initial
   begin
      valid_out = 1'b0;
      data_out = '0;
   end

   // entered at a falling edge, returns at the falling edge after acceptance
   task automatic send(input logic ch, input logic [31:0] smp);
      valid_out = 1'b1;
      data_out = '{ch: ch, smp: smp};
      // ready only moves on a rising edge, so it is settled here
      while (ready_in !== 1'b1)
         @(negedge ref_clk_in);
      @(negedge ref_clk_in);
   endtask

   // released lines show the inverse so a stale sample cannot pass
   task automatic idle();
      valid_out = 1'b0;
      data_out = ~data_out;
   endtask
endmodule
`default_nettype wire

// ==== sim/test_dqc_chain.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_dqc_chain;
   import dqc_pkg::*;
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
   } dqc_row_t;
   logic ref_clk_in;
   logic sys_rst_in;
   logic reg_wr;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata;
   logic [31:0] reg_rdata;
   logic in_valid;
   dqc_smp_t in_data;
   logic in_ready;
   logic out_valid;
   dqc_smp_t out_data;
   logic out_ready;
   int failures;
   int tests_run;
   int cycles;
   int n;
   int k;
   logic [31:0] got;
   logic [31:0] y1;
   dqc_row_t rows [9];

   dqc_chain DUT (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .reg_wr_in(reg_wr),
      .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata),
      .reg_rdata_out(reg_rdata),
      .in_valid_in(in_valid),
      .in_data_in(in_data),
      .in_ready_out(in_ready),
      .out_valid_out(out_valid),
      .out_data_out(out_data),
      .out_ready_in(out_ready)
   );

   dqc_up_model u_src (
      .ref_clk_in(ref_clk_in),
      .ready_in(in_ready),
      .valid_out(in_valid),
      .data_out(in_data)
   );

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk_in);
      reg_wr = 1'b0;
      reg_wdata = ~d;
      // one idle edge so a following write always re-raises the strobe from low
      @(negedge ref_clk_in);
   endtask

   // rdata is registered: one edge after the address settles
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      reg_addr = a;
      @(negedge ref_clk_in);
      d = reg_rdata;
   endtask

   // out_ready is held high, so the edge after sampling consumes the word
   task automatic take_out(input logic ch, input logic zero);
      k = 0;
      while (out_valid !== 1'b1 && k < 20)
      begin
         @(negedge ref_clk_in);
         k++;
      end
      got = out_data.smp;
      check({out_valid, out_data.ch}, {1'b1, ch});
      check(out_data.smp === 32'h0, zero);
      check(out_data.smp[31], 1'b0);
      @(negedge ref_clk_in);
   endtask

   initial
   begin
      ref_clk_in = 1'b0;
      forever
         #25 ref_clk_in = ~ref_clk_in;
   end

   initial
   begin
      cycles = 0;
      forever
      begin
         @(posedge ref_clk_in);
         cycles++;
         if (cycles == 5000)
         begin
            failures++;
            complete_run();
         end
      end
   end

   initial
   begin
      logic [31:0] rd;
      failures = 0;
      tests_run = 0;
      sys_rst_in = 1'b1;
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      out_ready = 1'b1;
      rows[0] = '{1'b0, 8'h40, 32'h0, 32'h40000000};
      rows[1] = '{1'b0, 8'h50, 32'h0, 32'h40000000};
      rows[2] = '{1'b0, 8'h54, 32'h0, 32'h7fffffff};
      rows[3] = '{1'b0, OFS_DEQ_ALPHA, 32'h0, 32'h0};
      rows[4] = '{1'b1, OFS_DEQ_ALPHA, 32'h12345678, 32'h12345678};
      rows[5] = '{1'b1, OFS_DEQ_GAIN, 32'h80000001, 32'h80000001};
      rows[6] = '{1'b1, OFS_DEQ_OFFSET, 32'hfedcba98, 32'hfedcba98};
      rows[7] = '{1'b1, OFS_METER_SEL, 32'h00000001, 32'h00000001};
      rows[8] = '{1'b1, OFS_SWAP, 32'h00000000, 32'h00000000};
      repeat (10)
         @(negedge ref_clk_in);
      sys_rst_in = 1'b0;
      @(negedge ref_clk_in);
      check({in_ready, out_valid, reg_rdata}, {2'b10, 32'h0});
      foreach (rows[i])
      begin
         if (rows[i].wr)
            reg_write(rows[i].a, rows[i].d);
         reg_read(rows[i].a, rd);
         check(rd, rows[i].e);
      end
      // all biquads zero: both blend paths give silence
      u_src.send(1'b0, 32'h20000000);
      u_src.send(1'b1, 32'h30000000);
      u_src.idle();
      take_out(1'b0, 1'b1);
      take_out(1'b1, 1'b1);
      reg_write(8'h00, 32'h7fffffff);
      reg_write(8'h14, 32'h7fffffff);
      u_src.send(1'b0, 32'h20000000);
      u_src.idle();
      take_out(1'b0, 1'b1);
      reg_write(OFS_SWAP, 32'h00000001);
      @(negedge ref_clk_in);
      u_src.send(1'b1, 32'h20000000);
      u_src.idle();
      take_out(1'b1, 1'b0);
      // stall the far side and fill until refused
      out_ready = 1'b0;
      n = 0;
      while (in_ready === 1'b1 && n < 40)
      begin
         u_src.send(n[0], 32'h10000000);
         n++;
      end
      u_src.idle();
      check(in_ready, 1'b0);
      check(n >= 16 && n < 40, 1'b1);
      out_ready = 1'b1;
      for (int j = 0; j < n; j++)
         take_out(j[0], 1'b0);
      repeat (5)
         @(negedge ref_clk_in);
      check({out_valid, in_ready}, 2'b01);
      // limiter and meter track at once; release step below attack step
      reg_write(8'h58, 32'h7fffffff);
      reg_write(8'hf0, 32'h04000000);
      reg_write(8'hf4, 32'h7fffffff);
      reg_write(8'hf8, 32'h08000000);
      reg_write(8'hfc, 32'h01000000);
      reg_write(OFS_SWAP, 32'h00000001);
      for (int j = 0; j < 3; j++)
      begin
         u_src.send(1'b0, 32'h20000000);
         u_src.idle();
         take_out(1'b0, 1'b0);
         if (j == 0)
            y1 = got;
      end
      check($signed(got) < $signed(y1), 1'b1);
      reg_read(OFS_METER_L, rd);
      check(rd[31], 1'b0);
      check(rd >= 32'h1fff0000 && rd <= 32'h20000000, 1'b1);
      // mid-run reset restores defaults and empties the path
      sys_rst_in = 1'b1;
      repeat (2)
         @(negedge ref_clk_in);
      sys_rst_in = 1'b0;
      reg_read(8'h58, rd);
      check({in_ready, out_valid, rd}, {2'b10, 32'h0});
      complete_run();
   end
endmodule
`default_nettype wire
